/* File: hw/pcm_pkg.sv */
package pcm_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_COUNTERS  = 3;             // Counters 0 to 2
    localparam int unsigned CNT_W         = 16;            // Count width
    localparam int unsigned ADDR_W        = 8;             // Register address width
    localparam int unsigned DATA_W        = 32;            // Register data width

    // ------------------------------------------------------------
    // Register map (per counter stride of 0x10)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL       = 8'h00;         // Mode, system, level, commit
    localparam logic [7:0] REG_COUNT      = 8'h04;         // Load value
    localparam logic [7:0] REG_FETCH      = 8'h08;         // Fetched count (read only)
    localparam logic [7:0] REG_MEAS       = 8'h0c;         // Measurement control and status
    localparam logic [7:0] REG_STRIDE     = 8'h10;         // Distance between counters
    localparam logic [31:0] RD_UNMAPPED   = 32'h0000_0000; // Answer to unmapped reads

    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_MODE_LSB = 0;             // Operating mode code, 3 bits
    localparam int unsigned CTRL_BCD_BIT  = 3;             // Number system select
    localparam int unsigned CTRL_LVL_BIT  = 4;             // Forced output level
    localparam int unsigned MEAS_KIND_LSB = 0;             // Measurement kind, 2 bits
    localparam int unsigned MEAS_SRC_LSB  = 2;             // Timebase select, 3 bits
    localparam int unsigned MEAS_EN_BIT   = 5;             // Measurement enable
    localparam int unsigned MEAS_GO_BIT   = 6;             // Start strobe (write)
    localparam int unsigned MEAS_BUSY_BIT = 8;             // Status: armed or running
    localparam int unsigned MEAS_DONE_BIT = 9;             // Status: result held
    localparam int unsigned MEAS_OVF_BIT  = 10;            // Status: overflow

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        mode_toggle_at_zero     = 3'h0,
        mode_single_pulse       = 3'h1,
        mode_periodic_pulse     = 3'h2,
        mode_square_output      = 3'h3,
        mode_level_gated_strobe = 3'h4,
        mode_edge_gated_strobe  = 3'h5,
        cmd_fetch_count         = 3'h6,
        cmd_reset_counter       = 3'h7
    } pcm_mode_t;

    typedef enum logic [1:0] {
        meas_high_width  = 2'h0,
        meas_low_width   = 2'h1,
        meas_rise_to_rise = 2'h2,
        meas_fall_to_fall = 2'h3
    } pcm_meas_kind_t;

    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_ARM  = 2'b01,
        MS_RUN  = 2'b11,
        MS_DONE = 2'b10
    } pcm_meas_state_t;

    // Timebase select codes; 0 is the external source pin
    localparam logic [2:0] TB_SOURCE_PIN  = 3'h0;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned TB_HZ [1:6]   = '{20_000_000, 1_000_000, 100_000, 10_000, 1_000, 100};
    localparam logic [15:0] BIN_MAX       = 16'hffff;      // Zero load in binary
    localparam logic [15:0] BCD_ZERO_LOAD = 16'h9999;      // Decrement from zero wraps here

    // Per counter pin group
    typedef struct packed {
        logic src;   // Count clock / source pin
        logic gate;  // Gate pin
    } pcm_pins_t;

endpackage

/* File: hw/pcm_counter_block.sv */
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module pcm_counter_block
    import pcm_pkg::*;
#(
    parameter int unsigned N_CNT = NUM_COUNTERS
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rstn_i,
    input  wire logic [ADDR_W-1:0]    addr_i,
    input  wire logic [DATA_W-1:0]    wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [DATA_W-1:0]    rdata_o,
    input  wire pcm_pins_t [N_CNT-1:0] pins_i,
    output logic      [N_CNT-1:0]     out_o
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;  // Two stage release of the async reset
    logic       rst_n;       // Synchronised reset used everywhere

    // Assert at once, release after two edges
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // Internal timebase ticks, shared by all counters
    // ------------------------------------------------------------
    logic [6:1] tb_tick;     // One cycle enable per fixed frequency

    // One divider per frequency; 20 MHz is not an integer divisor, so use a
    // phase accumulator which yields an exact average rate with jitter
    for (genvar t = 1; t <= 6; t++) begin : g_tb
        localparam logic [31:0] STEP = 32'(TB_HZ[t]);
        logic [31:0] acc_q;  // Phase accumulator
        always_ff @(posedge clk_sys_i or negedge rst_n) begin
            if (!rst_n) begin
                acc_q <= 32'h0000_0000;
            end else if (acc_q + STEP >= 32'(CLK_HZ)) begin
                acc_q <= acc_q + STEP - 32'(CLK_HZ);
            end else begin
                acc_q <= acc_q + STEP;
            end
        end
        assign tb_tick[t] = (acc_q + STEP >= 32'(CLK_HZ));
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_word [N_CNT];  // Read value of each counter slice
    logic [N_CNT-1:0]  hit;              // Address falls in a slice
    logic [7:0]        reg_off;          // Offset within a slice

    assign reg_off = addr_i & (REG_STRIDE - 8'h01);

    // ------------------------------------------------------------
    // Counter slices, one per counter
    // ------------------------------------------------------------
    for (genvar c = 0; c < N_CNT; c++) begin : g_cnt
        localparam logic [7:0] BASE = 8'(c * REG_STRIDE);
        pcm_mode_t       mode_q;     // Operating mode code
        logic            bcd_q;      // Number system select
        logic [CNT_W-1:0] load_q;    // Programmed count
        logic [CNT_W-1:0] cnt_q;     // Live count
        logic [CNT_W-1:0] fetched_count_q; // Latched for host
        logic            out_q;      // Output level
        logic            run_q;      // Counting armed
        logic            trig_q;     // Gate edge seen in edge modes
        logic [1:0]      src_s_q;    // Source pin synchroniser
        logic [1:0]      gate_s_q;   // Gate pin synchroniser
        logic            src_d1_q;   // Delayed source for edge detect
        logic            gate_d1_q;  // Delayed gate for edge detect
        logic            src_rise;   // Count clock edge
        logic            gate_rise;  // Gate rising edge
        logic            gate_fall;  // Gate falling edge
        logic            gate_lvl;   // Synchronised gate level
        logic            wr_ctrl;    // Control write
        logic            wr_cnt;     // Count write
        logic            wr_meas;    // Measurement control write
        logic [CNT_W-1:0] dec;       // Count minus one in current system
        logic [CNT_W-1:0] dec2;      // Count minus two (square wave)
        logic            at_one;     // Count about to reach zero
        pcm_meas_kind_t  kind_q;     // Measurement kind
        logic [2:0]      tbsel_q;    // Timebase select
        logic            meas_en_q;  // Slice is in measurement operation
        pcm_meas_state_t ms_q;       // Measurement state
        logic [CNT_W-1:0] meas_q;    // Measurement count
        logic            ovf_q;      // Measurement overflow
        logic            tb_en;      // Selected timebase enable
        logic            start_ev;   // Starting gate edge
        logic            end_ev;     // Ending gate edge

        assign hit[c]  = (addr_i & ~(REG_STRIDE - 8'h01)) == BASE;
        assign wr_ctrl = wr_i && hit[c] && reg_off == REG_CTRL;
        assign wr_cnt  = wr_i && hit[c] && reg_off == REG_COUNT;
        assign wr_meas = wr_i && hit[c] && reg_off == REG_MEAS;

        // Pin synchronisers; the first stage feeds only the second
        always_ff @(posedge clk_sys_i or negedge rst_n) begin
            if (!rst_n) begin
                src_s_q   <= 2'b00;
                gate_s_q  <= 2'b00;
                src_d1_q  <= 1'b0;
                gate_d1_q <= 1'b0;
            end else begin
                src_s_q   <= {src_s_q[0], pins_i[c].src};
                gate_s_q  <= {gate_s_q[0], pins_i[c].gate};
                src_d1_q  <= src_s_q[1];
                gate_d1_q <= gate_s_q[1];
            end
        end
        assign gate_lvl  = gate_s_q[1];
        assign src_rise  = src_s_q[1] & ~src_d1_q;
        assign gate_rise = gate_s_q[1] & ~gate_d1_q;
        assign gate_fall = ~gate_s_q[1] & gate_d1_q;

        // Decrement in binary or BCD; zero wraps to the largest count
        function automatic logic [CNT_W-1:0] step_down(input logic [CNT_W-1:0] v, input logic b);
            logic [CNT_W-1:0] r;
            logic             borrow;
            r      = v;
            borrow = 1'b1;
            if (!b) begin
                r = v - 16'h0001;
            end else begin
                for (int d = 0; d < 4; d++) begin
                    if (borrow) begin
                        if (v[d*4 +: 4] == 4'h0) begin
                            r[d*4 +: 4] = 4'h9;
                        end else begin
                            r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                            borrow      = 1'b0;
                        end
                    end
                end
            end
            return r;
        endfunction
        assign dec    = step_down(cnt_q, bcd_q);
        assign dec2   = step_down(dec, bcd_q);
        assign at_one = (cnt_q == 16'h0001);

        // Mode, number system and command handling
        always_ff @(posedge clk_sys_i or negedge rst_n) begin
            if (!rst_n) begin
                mode_q          <= mode_toggle_at_zero;
                bcd_q           <= 1'b0;
                fetched_count_q <= 16'h0000;
            end else if (wr_ctrl) begin
                if (pcm_mode_t'(wdata_i[CTRL_MODE_LSB +: 3]) == cmd_fetch_count) begin
                    fetched_count_q <= cnt_q;
                end else if (pcm_mode_t'(wdata_i[CTRL_MODE_LSB +: 3]) != cmd_reset_counter) begin
                    mode_q <= pcm_mode_t'(wdata_i[CTRL_MODE_LSB +: 3]);
                    bcd_q  <= wdata_i[CTRL_BCD_BIT];
                end
            end
        end

        // Load value register
        always_ff @(posedge clk_sys_i or negedge rst_n) begin
            if (!rst_n) begin
                load_q <= 16'h0000;
            end else if (wr_cnt) begin
                load_q <= wdata_i[CNT_W-1:0];
            end
        end

        // Waveform engine: advances on source pin rising edges
        always_ff @(posedge clk_sys_i or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q  <= 16'h0000;
                out_q  <= 1'b1;
                run_q  <= 1'b0;
                trig_q <= 1'b0;
            end else if (wr_ctrl && pcm_mode_t'(wdata_i[CTRL_MODE_LSB +: 3]) == cmd_reset_counter) begin
                cnt_q  <= 16'h0000;
                out_q  <= wdata_i[CTRL_LVL_BIT];
                run_q  <= 1'b0;
                trig_q <= 1'b0;
            end else if (wr_ctrl && pcm_mode_t'(wdata_i[CTRL_MODE_LSB +: 3]) != cmd_fetch_count) begin
                // Mode set: zero load stands for the largest count via wrap
                cnt_q  <= load_q;
                run_q  <= 1'b1;
                trig_q <= 1'b0;
                out_q  <= (wdata_i[CTRL_MODE_LSB +: 3] != 3'(mode_toggle_at_zero));
            end else if (gate_rise && (mode_q == mode_single_pulse || mode_q == mode_edge_gated_strobe)) begin
                // Edge modes retrigger: reload and arm, start on next count clock
                cnt_q  <= load_q;
                trig_q <= 1'b1;
                run_q  <= 1'b1;
            end else if (src_rise && run_q && !meas_en_q) begin
                unique case (mode_q)
                    mode_toggle_at_zero: begin
                        if (gate_lvl && !out_q) begin
                            cnt_q <= dec;
                            out_q <= at_one;
                        end
                    end
                    mode_single_pulse: begin
                        if (trig_q) begin
                            out_q  <= 1'b0;
                            trig_q <= 1'b0;
                        end else if (!out_q) begin
                            cnt_q <= dec;
                            out_q <= at_one;
                        end
                    end
                    mode_periodic_pulse: begin
                        if (gate_lvl) begin
                            cnt_q <= at_one ? load_q : dec;
                            out_q <= !(cnt_q == 16'h0002);
                        end
                    end
                    mode_square_output: begin
                        if (gate_lvl) begin
                            // Step by two; an odd count gives both halves the same rounded-up length
                            if (cnt_q <= 16'h0002 && cnt_q != 16'h0000) begin
                                cnt_q <= load_q;
                                out_q <= ~out_q;
                            end else begin
                                cnt_q <= dec2;
                            end
                        end
                    end
                    mode_level_gated_strobe, mode_edge_gated_strobe: begin
                        if (!out_q) begin
                            out_q <= 1'b1;
                            run_q <= 1'b0;
                        end else if ((mode_q == mode_level_gated_strobe && gate_lvl) || trig_q) begin
                            cnt_q <= dec;
                            if (at_one) begin
                                out_q  <= 1'b0;
                                trig_q <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        out_q <= out_q;
                    end
                endcase
            end
        end

        // Measurement timebase selection
        assign tb_en = (tbsel_q == TB_SOURCE_PIN) ? src_rise :
                       (tbsel_q <= 3'h6) ? tb_tick[tbsel_q] : 1'b0;

        // Start and end events per measurement kind
        always_comb begin
            start_ev = 1'b0;
            end_ev   = 1'b0;
            unique case (kind_q)
                meas_high_width:   begin start_ev = gate_rise; end_ev = gate_fall; end
                meas_low_width:    begin start_ev = gate_fall; end_ev = gate_rise; end
                meas_rise_to_rise: begin start_ev = gate_rise; end_ev = gate_rise; end
                meas_fall_to_fall: begin start_ev = gate_fall; end_ev = gate_fall; end
            endcase
        end

        // Measurement configuration
        always_ff @(posedge clk_sys_i or negedge rst_n) begin
            if (!rst_n) begin
                kind_q    <= meas_high_width;
                tbsel_q   <= TB_SOURCE_PIN;
                meas_en_q <= 1'b0;
            end else if (wr_meas) begin
                kind_q    <= pcm_meas_kind_t'(wdata_i[MEAS_KIND_LSB +: 2]);
                tbsel_q   <= wdata_i[MEAS_SRC_LSB +: 3];
                meas_en_q <= wdata_i[MEAS_EN_BIT];
            end
        end

        // Measurement sequencer: idle until started, then hold the result
        always_ff @(posedge clk_sys_i or negedge rst_n) begin
            if (!rst_n) begin
                ms_q   <= MS_IDLE;
                meas_q <= 16'h0000;
                ovf_q  <= 1'b0;
            end else if (wr_meas) begin
                ms_q   <= (wdata_i[MEAS_EN_BIT] && wdata_i[MEAS_GO_BIT]) ? MS_ARM : MS_IDLE;
                meas_q <= 16'h0000;
                ovf_q  <= 1'b0;
            end else begin
                unique case (ms_q)
                    MS_IDLE: ms_q <= MS_IDLE;
                    MS_ARM:  if (start_ev) ms_q <= MS_RUN;
                    MS_RUN: begin
                        if (end_ev) begin
                            ms_q <= MS_DONE;
                        end else if (tb_en) begin
                            meas_q <= meas_q + 16'h0001;
                            if (meas_q == BIN_MAX) ovf_q <= 1'b1;
                        end
                    end
                    MS_DONE: ms_q <= MS_DONE;
                endcase
            end
        end

        // Read mux of this slice
        always_comb begin
            rd_word[c] = RD_UNMAPPED;
            unique case (reg_off)
                REG_CTRL:  rd_word[c] = {27'h0, out_q, bcd_q, 1'b0, mode_q[1:0]} | {29'h0, mode_q};
                REG_COUNT: rd_word[c] = {16'h0, load_q};
                REG_FETCH: rd_word[c] = {16'h0, fetched_count_q};
                REG_MEAS:  rd_word[c] = {meas_q, 5'h0, ovf_q, ms_q == MS_DONE, ms_q == MS_RUN || ms_q == MS_ARM,
                                         2'b00, meas_en_q, tbsel_q, kind_q};
                default:   rd_word[c] = RD_UNMAPPED;
            endcase
        end
        assign out_o[c] = out_q;
    end

    // ------------------------------------------------------------
    // Read data, valid the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= RD_UNMAPPED;
        end else if (rd_i) begin
            rdata_o <= RD_UNMAPPED;
            for (int k = 0; k < N_CNT; k++) begin
                if (hit[k]) rdata_o <= rd_word[k];
            end
        end else begin
            rdata_o <= RD_UNMAPPED;
        end
    end

endmodule

/* File: tb/pcm_pin_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Pin driver: source and gate of each counter
// ------------------------------------------------------------
module pcm_pin_model
    import pcm_pkg::*;
(
    input  wire logic       clk_sys_i,
    output pcm_pins_t [2:0] pins_o
);
    initial pins_o = '0; // Source stands still and gates low until asked
    // Source pulses are 4 cycles wide so the 2 FF synchroniser never misses one
    task automatic pulse(input int c, input int n);
        repeat (n) begin
            @(posedge clk_sys_i) pins_o[c].src <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            pins_o[c].src <= 1'b0;
            repeat (4) @(posedge clk_sys_i);
        end
        @(negedge clk_sys_i);
    endtask
    // Gate change, then time for the edge detector to settle
    task automatic gate(input int c, input logic v);
        @(posedge clk_sys_i) pins_o[c].gate <= v;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
endmodule

/* File: tb/pcm_chk.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module pcm_chk
    import pcm_pkg::*;
#(
    parameter int unsigned N_CNT = NUM_COUNTERS
) (
    input wire logic                  clk_sys_i,
    input wire logic                  rstn_i,
    input wire logic [ADDR_W-1:0]     addr_i,
    input wire logic [DATA_W-1:0]     wdata_i,
    input wire logic                  wr_i,
    input wire logic                  rd_i,
    input wire logic [DATA_W-1:0]     rdata_o,
    input wire pcm_pins_t [N_CNT-1:0] pins_i,
    input wire logic [N_CNT-1:0]      out_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    property p_rd_idle; !$past(rd_i) |-> rdata_o == '0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_unmapped; rd_i && addr_i == 8'h30 |=> rdata_o == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("fourth counter answered");
    property p_mode0; wr_i && addr_i == 8'h00 && wdata_i[2:0] == 3'h0 |-> ##[1:2] !out_o[0]; endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 output not low");
    property p_mode4; wr_i && addr_i == 8'h10 && wdata_i[2:0] == 3'h4 |-> ##[1:2] out_o[1]; endproperty
    a_mode4: assert property (p_mode4) else $error("mode 4 output not high");
    property p_mode2; wr_i && addr_i == 8'h20 && wdata_i[2:0] == 3'h2 |-> ##[1:2] out_o[2]; endproperty
    a_mode2: assert property (p_mode2) else $error("mode 2 output not high");
    property p_lvl_lo; wr_i && addr_i == 8'h20 && wdata_i[4:0] == 5'h07 |-> ##[1:2] !out_o[2]; endproperty
    a_lvl_lo: assert property (p_lvl_lo) else $error("forced low missed");
    property p_lvl_hi; wr_i && addr_i == 8'h20 && wdata_i[4:0] == 5'h17 |-> ##[1:2] out_o[2]; endproperty
    a_lvl_hi: assert property (p_lvl_hi) else $error("forced high missed");
    property p_meas; rd_i && addr_i[3:0] == 4'hc |=> !(rdata_o[MEAS_BUSY_BIT] && rdata_o[MEAS_DONE_BIT]); endproperty
    a_meas: assert property (p_meas) else $error("busy and done together");
endmodule
bind pcm_counter_block pcm_chk #(.N_CNT(N_CNT)) pcm_chk_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins_i), .out_o(out_o));

/* File: tb/pcm_counter_block_bench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module pcm_counter_block_bench;
    import pcm_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              clk_sys_i = 1'b0;
    logic              rstn_i    = 1'b0;
    logic [ADDR_W-1:0] addr_i    = '0;
    logic [DATA_W-1:0] wdata_i   = '0;
    logic              wr_i      = 1'b0;
    logic              rd_i      = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    pcm_pins_t [2:0]   pins;
    logic [2:0]        out_o;
    int                fail_count = 0;
    int                checked    = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    pcm_counter_block pcm_counter_block_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pins_i(pins), .out_o(out_o));
    pcm_pin_model pcm_pin_model_inst (.clk_sys_i(clk_sys_i), .pins_o(pins));
    // ------------------------------------------------------------
    // Bus tasks; both end at a falling edge so outputs are settled
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        v = rdata_o;
    endtask
    // Latch the count of counter 0 and compare it
    task automatic fetch(input logic [31:0] cmd, input logic [15:0] e);
        logic [31:0] v;
        wr(8'h00, cmd);
        rd(8'h08, v);
        `CHK(v[15:0], e)
    endtask
    task automatic complete_run();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        fail_count++;
        complete_run();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        int          lows;
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        wr(8'h04, 32'h3);
        wr(8'h00, 32'h0);
        `CHK(out_o[0], 1'b0)
        pcm_pin_model_inst.pulse(0, 3);
        `CHK(out_o[0], 1'b0)
        pcm_pin_model_inst.gate(0, 1'b1);
        pcm_pin_model_inst.pulse(0, 1);
        fetch(32'h6, 16'h0002);
        pcm_pin_model_inst.pulse(0, 1);
        `CHK(out_o[0], 1'b0)
        pcm_pin_model_inst.pulse(0, 1);
        `CHK(out_o[0], 1'b1)
        for (int s = 0; s < 2; s++) begin
            wr(8'h04, 32'h0);
            wr(8'h00, s ? 32'h8 : 32'h0);
            pcm_pin_model_inst.pulse(0, 2);
            fetch(s ? 32'he : 32'h6, s ? 16'h9998 : 16'hfffe);
        end
        wr(8'h14, 32'h2);
        wr(8'h10, 32'h4);
        pcm_pin_model_inst.pulse(1, 2);
        `CHK(out_o[1], 1'b1)
        pcm_pin_model_inst.gate(1, 1'b1);
        pcm_pin_model_inst.pulse(1, 2);
        `CHK(out_o[1], 1'b0)
        pcm_pin_model_inst.pulse(1, 1);
        `CHK(out_o[1], 1'b1)
        wr(8'h10, 32'h5);
        pcm_pin_model_inst.pulse(1, 2);
        `CHK(out_o[1], 1'b1)
        pcm_pin_model_inst.gate(1, 1'b0);
        pcm_pin_model_inst.gate(1, 1'b1);
        pcm_pin_model_inst.pulse(1, 2);
        `CHK(out_o[1], 1'b0)
        // Single pulse: the gate edge arms, the next count clock drops the output
        wr(8'h10, 32'h1);
        pcm_pin_model_inst.gate(1, 1'b0);
        pcm_pin_model_inst.gate(1, 1'b1);
        pcm_pin_model_inst.pulse(1, 1);
        `CHK(out_o[1], 1'b0)
        pcm_pin_model_inst.pulse(1, 2);
        `CHK(out_o[1], 1'b1)
        // Twelve source edges hold whole periods, so the low count is phase free
        pcm_pin_model_inst.gate(2, 1'b1);
        for (int m = 2; m < 4; m++) begin
            wr(8'h24, m + 1);
            wr(8'h20, m);
            lows = 0;
            repeat (12) begin
                pcm_pin_model_inst.pulse(2, 1);
                lows += (out_o[2] === 1'b0);
            end
            `CHK(lows, m == 2 ? 4 : 6)
        end
        for (int l = 0; l < 2; l++) begin
            wr(8'h20, 32'h7 | (l << 4));
            `CHK(out_o[2], l[0])
        end
        wr(8'h30, 32'h5);
        rd(8'h30, d);
        `CHK(d, 32'h0)
        // Edges before the start edge and after the end edge must not count
        for (int k = 0; k < 4; k++) begin
            pcm_pin_model_inst.gate(0, k[0]);
            wr(8'h0c, 32'h60 | k);
            pcm_pin_model_inst.pulse(0, 2);
            pcm_pin_model_inst.gate(0, !k[0]);
            pcm_pin_model_inst.pulse(0, 4);
            pcm_pin_model_inst.gate(0, k[0]);
            pcm_pin_model_inst.pulse(0, 2);
            pcm_pin_model_inst.gate(0, !k[0]);
            pcm_pin_model_inst.pulse(0, 4);
            rd(8'h0c, d);
            `CHK(d[31:16], k[1] ? 16'h6 : 16'h4)
            `CHK(d[MEAS_DONE_BIT], 1'b1)
            `CHK(d[MEAS_OVF_BIT], 1'b0)
        end
        // 1 MHz timebase over a 200 cycle high pulse at 20 ns gives 4 ticks
        wr(8'h0c, 32'h68);
        pcm_pin_model_inst.gate(0, 1'b1);
        repeat (196) @(posedge clk_sys_i);
        pcm_pin_model_inst.gate(0, 1'b0);
        rd(8'h0c, d);
        `CHK(d[31:16], 16'h4)
        complete_run();
    end
endmodule
